// ### testbench.sv
// Self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ps
module testbench;
	logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, arb_lost_i = 0;
	logic [3:0]  wb_adr_i = 0, wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, seed = 20;
	logic [6:0]  own;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, start_gen_o, m_scl, m_sda;
	wire         scl = !(scl_oe_o | m_scl);
	wire         sda = !(sda_oe_o | m_sda);
	int          mismatches = 0, comparisons = 0;
	always #2.5 clk_i = ~clk_i;
	tws_slave_tx dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl), .scl_o(scl_o),
		.scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.arb_lost_i(arb_lost_i), .start_gen_o(start_gen_o));
	tws_mrx m_u (.scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl), .sda_oe_o(m_sda));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] code(input int i, input int n, input logic l, input logic x);
		if (i == 0) return l ? 8'hB0 : 8'hA8;
		if (i < n) return 8'hB8;
		return x ? 8'hC8 : 8'hC0;
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, w, a, 4'hF};
		wb_dat_i <= {24'h0, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic wait_stat(input logic [7:0] e);
		logic [7:0] q;
		q = 8'hF8;
		while (q === 8'hF8) wb(0, 4'h8, 0, q);
		chk("status", e, q);
	endtask
	task automatic probe(input logic [7:0] a, input logic e);
		logic [7:0] q;
		logic r;
		m_u.start();
		m_u.xfer(a, 1, q, r);
		m_u.stop();
		chk("probe ack", e, r);
		$display("probe %h done", a);
	endtask
	task automatic frame(input int n, input logic l, input logic x, input logic [7:0] fin);
		logic [7:0] d[8];
		logic [7:0] q, w;
		logic r;
		for (int i = 0; i < 8; i++) d[i] = xs(seed + i);
		fork
			begin
				m_u.start();
				if (l) begin
					@(posedge clk_i) arb_lost_i <= 1;
					@(posedge clk_i) arb_lost_i <= 0;
				end
				m_u.xfer({own, 1'b1}, 1, q, r);
				chk("address ack", 0, r);
				for (int i = 0; i < n + x; i++) begin
					m_u.xfer(8'hFF, i == n + x - 1, q, r);
					chk("data", i < n ? d[i] : 8'hFF, q);
				end
				m_u.stop();
			end
			begin
				for (int i = 0; i < n; i++) begin
					wait_stat(code(i, n, l, x));
					wb(1, 4'hC, d[i], w);
					wb(1, 4'h4, i == n - 1 ? 8'h48 : 8'h4C, w);
				end
				wait_stat(code(n, n, l, x));
				wb(1, 4'h4, fin, w);
				for (int k = 0; k < 4000 && fin[5] && start_gen_o !== 1'b1; k++) @(posedge clk_i);
				if (fin[5]) chk("start pulse", 1, start_gen_o);
			end
		join
		if (fin[5]) wb(1, 4'h4, 8'h4C, w);
		$display("frame of %0d bytes done", n);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
	initial begin
		logic [7:0] q;
		logic       r;
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		repeat (3) @(posedge clk_i);
		seed = xs(seed);
		own = seed[6:0] | 7'h08;
		wb(0, 4'h8, 0, q);
		chk("idle status", 8'hF8, q);
		wb(0, 4'h2, 0, q);
		chk("unmapped", 8'h00, q);
		wb(1, 4'h0, {own, 1'b0}, q);
		wb(0, 4'h0, 0, q);
		chk("own address", {own, 1'b0}, q);
		wb(1, 4'h4, 8'h4C, q);
		probe(8'h00, 1);
		probe({own ^ 7'h01, 1'b1}, 1);
		frame(1, 0, 0, 8'h4C);
		m_u.start();
		for (int k = 0; k < 3; k++) m_u.bit_io(1, r);
		m_u.stop();
		wait_stat(8'h00);
		wb(1, 4'h4, 8'h5C, q);
		wb(0, 4'h4, 0, q);
		chk("error recovery", 8'h44, q);
		$display("bus error done");
		frame(4, 0, 1, 8'h48);
		probe({own, 1'b1}, 1);
		wb(1, 4'h4, 8'h4C, q);
		frame(3, 1, 0, 8'h6C);
		wb(1, 4'h0, {own, 1'b1}, q);
		probe(8'h00, 0);
		wait_stat(8'h70);
		wb(1, 4'h4, 8'h4C, q);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			frame(1 + seed[1:0], seed[2], seed[3], 8'h4C);
		end
		complete_run();
	end
endmodule // testbench

// ### tws_defines.vh
// Constants for the two-wire slave transmitter
// Notes on behaviour
// - Match upper seven address bits, else ignore
// - Address LSB enables general call 00h
// - Read bit selects transmit, else address acknowledged then ignored
// - Own address read acknowledged gives A8h
// - Lost arbitration then addressed for read gives B0h
// - Acknowledge enable zero marks final byte
// - Non-final byte acknowledged by master gives B8h
// - Final byte ends in C0h or C8h
// - After C8h ignore master, data released
// - Acknowledge enable zero blocks address recognition
// - Reply without acknowledge enable disables recognition
// - Reply with acknowledge enable restores recognition
// - Start request reply to C0h or C8h issues START when free
// - Status reads F8h while flag clear
// - Misplaced START/STOP gives 00h, stop recovers
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH

// Register byte offsets
`define TWS_OFS_ADDR      4'h0
`define TWS_OFS_CTRL      4'h4
`define TWS_OFS_STAT      4'h8
`define TWS_OFS_DATA      4'hC

// Control field positions
`define TWS_CTRL_IFEN     6
`define TWS_CTRL_START    5
`define TWS_CTRL_STOP     4
`define TWS_CTRL_FLAG     3
`define TWS_CTRL_ACKEN    2

// Reset values
`define TWS_RST_ADDR      8'h00
`define TWS_RST_DATA      8'h00

// Status codes
`define TWS_ST_OWN_W      8'h60
`define TWS_ST_LOST_W     8'h68
`define TWS_ST_GC_W       8'h70
`define TWS_ST_LOST_GC    8'h78
`define TWS_ST_OWN_R      8'hA8
`define TWS_ST_LOST_R     8'hB0
`define TWS_ST_TX_ACK     8'hB8
`define TWS_ST_TX_NACK    8'hC0
`define TWS_ST_LAST_ACK   8'hC8
`define TWS_ST_NONE       8'hF8
`define TWS_ST_BUS_ERR    8'h00

// General call address byte
`define TWS_GC_ADDR       8'h00

`endif

// ### tws_mrx.sv
// Master receiver model on the two-wire bus
`timescale 1ns/1ps
module tws_mrx (
	// Wire levels
	input  wire scl_i,
	input  wire sda_i,
	// Pull-down enables
	output reg  scl_oe_o,
	output reg  sda_oe_o
);
	initial begin
		scl_oe_o = 0;
		sda_oe_o = 0;
	end
	// One bit, waiting while the slave stretches
	task automatic bit_io(input logic b, output logic r);
		sda_oe_o = !b;
		#40 scl_oe_o = 0;
		wait (scl_i === 1'b1);
		#40 r = sda_i;
		#40 scl_oe_o = 1;
		#40;
	endtask
	task automatic start();
		#80 sda_oe_o = 1;
		#80 scl_oe_o = 1;
		#40;
	endtask
	task automatic stop();
		sda_oe_o = 1;
		#40 scl_oe_o = 0;
		#80 sda_oe_o = 0;
		#80;
	endtask
	// Byte MSB first, then the ninth bit
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(a, r);
	endtask
endmodule // tws_mrx

// ### tws_props.sv
// Port checker for the two-wire slave transmitter
`timescale 1ns/1ps
module tws_props (
	// Clock, reset and register bus
	input logic        clk_i,
	input logic        rst_i,
	input logic        wb_cyc_i,
	input logic        wb_stb_i,
	input logic        wb_we_i,
	input logic [3:0]  wb_adr_i,
	input logic [3:0]  wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic [31:0] wb_dat_o,
	input logic        wb_ack_o,
	// Two-wire pins and master handshake
	input logic        scl_i,
	input logic        scl_o,
	input logic        scl_oe_o,
	input logic        sda_i,
	input logic        sda_o,
	input logic        sda_oe_o,
	input logic        arb_lost_i,
	input logic        start_gen_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus answer missing");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 0 |-> wb_dat_o == 0)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 0)
		else $error("upper read bits set");
	chk_open_drain: assert property (!scl_o && !sda_o)
		else $error("pin driven high");
	chk_stretch_hold: assert property ($fell(scl_oe_o) |-> $past(wb_we_i, 2) || $past(wb_we_i, 3) || $past(wb_we_i, 4))
		else $error("stretch released without write");
	chk_start_free: assert property (start_gen_o |-> scl_i && sda_i ##1 !start_gen_o)
		else $error("start request on busy bus");
	chk_sda_low_clock: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("data pulled while clock high");
	chk_reset_quiet: assert property ($past(rst_i) |-> !wb_ack_o && !scl_oe_o && !sda_oe_o)
		else $error("outputs active after reset");
	cover property (start_gen_o);
	cover property ($rose(scl_oe_o));
	cover property (wb_ack_o && wb_we_i);
endmodule // tws_props

bind tws_slave_tx tws_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i),
	.scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.arb_lost_i(arb_lost_i), .start_gen_o(start_gen_o));

// ### tws_slave_tx.v
// Two-wire slave transmitter with Wishbone registers
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "tws_defines.vh"
module tws_slave_tx (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Two-wire bus pins
	input  wire        scl_i,
	output reg         scl_o,
	output reg         scl_oe_o,
	input  wire        sda_i,
	output reg         sda_o,
	output reg         sda_oe_o,
	// Master logic handshake
	input  wire        arb_lost_i,
	output reg         start_gen_o
);

	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_ADDR = 8'h02;
	localparam [7:0] S_AACK = 8'h04;
	localparam [7:0] S_TX   = 8'h08;
	localparam [7:0] S_RACK = 8'h10;
	localparam [7:0] S_HOLD = 8'h20;
	localparam [7:0] S_IGN  = 8'h40;
	localparam [7:0] S_BERR = 8'h80;

	reg  [7:0] own_address_reg;
	reg  [7:0] serial_data_reg;
	reg  [7:0] status_code_reg;
	reg        iface_enable_reg;
	reg        ack_enable_reg;
	reg        start_request_reg;
	reg        stop_request_reg;
	reg        flag_reg;
	reg  [7:0] state_reg;
	reg  [7:0] shift_reg;
	reg  [2:0] cnt_reg;
	reg        bdone_reg;
	reg        rd_reg;
	reg        gc_reg;
	reg        lost_reg;
	reg        last_reg;
	reg        mack_reg;
	reg        end_reg;
	reg        start_pend_reg;
	reg        busy_reg;
	reg        scl_d_reg;
	reg        sda_d_reg;
	wire [1:0] pins_sync;
	wire       scl_s;
	wire       sda_s;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_ev;
	wire       stop_ev;
	wire       wb_req;
	wire       wr_ctrl;
	wire       sw_clr;
	wire       own_hit;
	wire       gc_hit;
	wire       illegal;
	wire [7:0] stat_view;

	// Address-phase status code
	function [7:0] addr_code;
		input rd;
		input gc;
		input lost;
		begin
			if (rd)
				addr_code = lost ? `TWS_ST_LOST_R : `TWS_ST_OWN_R;
			else if (gc)
				addr_code = lost ? `TWS_ST_LOST_GC : `TWS_ST_GC_W;
			else
				addr_code = lost ? `TWS_ST_LOST_W : `TWS_ST_OWN_W;
		end
	endfunction

	tws_sync2 #(
		.WIDTH(2)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({scl_i, sda_i}),
		.sync_o  (pins_sync)
	);

	assign scl_s    = pins_sync[1];
	assign sda_s    = pins_sync[0];
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	assign wb_req  = wb_cyc_i & wb_stb_i & wb_ack_o;
	assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `TWS_OFS_CTRL);
	assign sw_clr  = wr_ctrl & wb_dat_i[`TWS_CTRL_FLAG];

	assign own_hit = ack_enable_reg & (shift_reg[7:1] == own_address_reg[7:1]);
	assign gc_hit  = ack_enable_reg & own_address_reg[0] & (shift_reg == `TWS_GC_ADDR);

	assign illegal = ((state_reg == S_ADDR) & ((cnt_reg != 3'h0) | bdone_reg))
		| (state_reg == S_AACK) | (state_reg == S_TX) | (state_reg == S_RACK);

	assign stat_view = flag_reg ? status_code_reg : `TWS_ST_NONE;

	// Wishbone answer one cycle after request
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			case (wb_adr_i)
				`TWS_OFS_ADDR: wb_dat_o <= {24'h00_0000, own_address_reg};
				`TWS_OFS_CTRL: wb_dat_o <= {25'h000_0000, iface_enable_reg,
					start_request_reg, stop_request_reg, flag_reg, ack_enable_reg, 2'h0};
				`TWS_OFS_STAT: wb_dat_o <= {24'h00_0000, stat_view};
				`TWS_OFS_DATA: wb_dat_o <= {24'h00_0000, serial_data_reg};
				default:       wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Software-owned registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			own_address_reg   <= `TWS_RST_ADDR;
			serial_data_reg   <= `TWS_RST_DATA;
			iface_enable_reg  <= 1'b0;
			ack_enable_reg    <= 1'b0;
			start_request_reg <= 1'b0;
		end else if (wb_req & wb_we_i & wb_sel_i[0]) begin
			if (wb_adr_i == `TWS_OFS_ADDR)
				own_address_reg <= wb_dat_i[7:0];
			if (wb_adr_i == `TWS_OFS_DATA)
				serial_data_reg <= wb_dat_i[7:0];
			if (wb_adr_i == `TWS_OFS_CTRL) begin
				iface_enable_reg  <= wb_dat_i[`TWS_CTRL_IFEN];
				ack_enable_reg    <= wb_dat_i[`TWS_CTRL_ACKEN];
				start_request_reg <= wb_dat_i[`TWS_CTRL_START];
			end
		end
	end

	// Bus busy tracking and deferred START
	always @(posedge clk_i) begin
		if (rst_i) begin
			scl_d_reg      <= 1'b1;
			sda_d_reg      <= 1'b1;
			busy_reg       <= 1'b0;
			start_pend_reg <= 1'b0;
			start_gen_o    <= 1'b0;
			end_reg        <= 1'b0;
		end else begin
			scl_d_reg   <= scl_s;
			sda_d_reg   <= sda_s;
			start_gen_o <= 1'b0;
			if (start_ev)
				busy_reg <= 1'b1;
			else if (stop_ev)
				busy_reg <= 1'b0;
			if (end_reg & ~flag_reg) begin
				end_reg        <= 1'b0;
				start_pend_reg <= start_request_reg;
			end else if (start_pend_reg & ~busy_reg & iface_enable_reg) begin
				start_pend_reg <= 1'b0;
				start_gen_o    <= 1'b1;
			end
			if (state_reg == S_RACK && scl_fall && bdone_reg && !(mack_reg && !last_reg))
				end_reg <= 1'b1;
		end
	end

	// Protocol engine, flag and status
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg        <= S_IDLE;
			shift_reg        <= 8'h00;
			cnt_reg          <= 3'h0;
			bdone_reg        <= 1'b0;
			rd_reg           <= 1'b0;
			gc_reg           <= 1'b0;
			lost_reg         <= 1'b0;
			last_reg         <= 1'b0;
			mack_reg         <= 1'b0;
			flag_reg         <= 1'b0;
			stop_request_reg <= 1'b0;
			status_code_reg  <= `TWS_ST_NONE;
			scl_o            <= 1'b0;
			sda_o            <= 1'b0;
			scl_oe_o         <= 1'b0;
			sda_oe_o         <= 1'b0;
		end else begin
			if (sw_clr)
				flag_reg <= 1'b0;
			if (wr_ctrl)
				stop_request_reg <= wb_dat_i[`TWS_CTRL_STOP];
			if (arb_lost_i)
				lost_reg <= 1'b1;
			if (!iface_enable_reg) begin
				state_reg <= S_IDLE;
				scl_oe_o  <= 1'b0;
				sda_oe_o  <= 1'b0;
			end else if ((start_ev | stop_ev) & illegal) begin
				state_reg       <= S_BERR;
				status_code_reg <= `TWS_ST_BUS_ERR;
				flag_reg        <= 1'b1;
				scl_oe_o        <= 1'b0;
				sda_oe_o        <= 1'b0;
			end else if (start_ev & (state_reg != S_BERR) & (state_reg != S_HOLD)) begin
				state_reg <= S_ADDR;
				cnt_reg   <= 3'h0;
				bdone_reg <= 1'b0;
				sda_oe_o  <= 1'b0;
			end else if (stop_ev & (state_reg != S_BERR) & (state_reg != S_HOLD)) begin
				state_reg <= S_IDLE;
				lost_reg  <= 1'b0;
				sda_oe_o  <= 1'b0;
			end else begin
				case (state_reg)
					S_ADDR: begin
						if (scl_rise) begin
							shift_reg <= {shift_reg[6:0], sda_s};
							cnt_reg   <= cnt_reg + 3'h1;
							bdone_reg <= (cnt_reg == 3'h7);
						end else if (scl_fall & bdone_reg) begin
							bdone_reg <= 1'b0;
							if (own_hit | gc_hit) begin
								rd_reg    <= shift_reg[0] & own_hit;
								gc_reg    <= gc_hit;
								sda_oe_o  <= 1'b1;
								state_reg <= S_AACK;
							end else begin
								state_reg <= S_IGN;
							end
						end
					end
					S_AACK: begin
						if (scl_fall) begin
							sda_oe_o        <= 1'b0;
							flag_reg        <= 1'b1;
							lost_reg        <= 1'b0;
							status_code_reg <= addr_code(rd_reg, gc_reg, lost_reg);
							if (rd_reg) begin
								scl_oe_o  <= 1'b1;
								state_reg <= S_HOLD;
							end else begin
								state_reg <= S_IGN;
							end
						end
					end
					S_HOLD: begin
						if (!flag_reg) begin
							last_reg  <= ~ack_enable_reg;
							shift_reg <= {serial_data_reg[6:0], 1'b1};
							sda_oe_o  <= ~serial_data_reg[7];
							cnt_reg   <= 3'h0;
							state_reg <= S_TX;
						end
					end
					S_TX: begin
						scl_oe_o <= 1'b0;
						if (scl_fall) begin
							cnt_reg <= cnt_reg + 3'h1;
							if (cnt_reg == 3'h7) begin
								sda_oe_o  <= 1'b0;
								bdone_reg <= 1'b0;
								state_reg <= S_RACK;
							end else begin
								sda_oe_o  <= ~shift_reg[7];
								shift_reg <= {shift_reg[6:0], 1'b1};
							end
						end
					end
					S_RACK: begin
						if (scl_rise) begin
							mack_reg  <= ~sda_s;
							bdone_reg <= 1'b1;
						end else if (scl_fall & bdone_reg) begin
							bdone_reg <= 1'b0;
							flag_reg  <= 1'b1;
							if (mack_reg & ~last_reg) begin
								status_code_reg <= `TWS_ST_TX_ACK;
								scl_oe_o        <= 1'b1;
								state_reg       <= S_HOLD;
							end else if (~mack_reg) begin
								status_code_reg <= `TWS_ST_TX_NACK;
								state_reg       <= S_IGN;
							end else begin
								status_code_reg <= `TWS_ST_LAST_ACK;
								state_reg       <= S_IGN;
							end
						end
					end
					S_BERR: begin
						if (!flag_reg & stop_request_reg) begin
							stop_request_reg <= 1'b0;
							state_reg        <= S_IDLE;
						end
					end
					S_IDLE, S_IGN: begin
						sda_oe_o <= 1'b0;
						scl_oe_o <= 1'b0;
					end
					default: begin
						state_reg <= S_IDLE;
					end
				endcase
			end
		end
	end

endmodule // tws_slave_tx

// ### tws_sync2.v
// Two-flop synchroniser for bus pins
`timescale 1ns/1ps
module tws_sync2 #(
	parameter WIDTH = 2
) (
	// Clock and reset
	input  wire             clk_i,
	input  wire             rst_i,
	// Pins in, synchronised out
	input  wire [WIDTH-1:0] async_i,
	output reg  [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta_reg;

	// Idle bus reads high
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= {WIDTH{1'b1}};
			sync_o   <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule // tws_sync2
